//--- verilog/rfo_pkg.sv
package rfo_pkg;
    // register indices and byte addresses
    localparam logic [7:0] IDX_FRAME = 8'h07;
    localparam logic [7:0] IDX_STREAM = 8'h08;
    localparam logic [7:0] IDX_AUX = 8'h09;
    localparam logic [11:0] ADDR_FRAME = {2'h0, IDX_FRAME, 2'h0};
    localparam logic [11:0] ADDR_STREAM = {2'h0, IDX_STREAM, 2'h0};
    localparam logic [11:0] ADDR_AUX = {2'h0, IDX_AUX, 2'h0};
    // reset values
    localparam logic [7:0] RST_FRAME = 8'h00;
    localparam logic [6:0] RST_STREAM = 7'h00;
    localparam logic [7:0] RST_AUX = 8'h04;
    // field positions, frame options
    localparam int B_TR1 = 6;
    localparam int B_NO_SOF = 5;
    localparam int B_NO_EOF = 4;
    localparam int B_LONG_EOF = 3;
    localparam int B_PHASE = 2;
    localparam int B_PREAMBLE = 0;
    // field positions, stream timing
    localparam int B_SCF = 5;
    localparam int B_SCP = 3;
    localparam int B_STX = 0;
    // field positions, auxiliary
    localparam int B_NO_CRC = 7;
    localparam int B_CRC_FIFO = 6;
    localparam int B_MOD = 5;
    localparam int B_FD = 4;
    localparam int B_OOK_HIZ = 3;
    localparam int B_RX_TOL = 2;
    localparam int B_FIELD_N = 0;
    // receive rate codes
    localparam logic [1:0] RATE_128 = 2'h0;
    localparam logic [1:0] RATE_16UP = 2'h3;
    // decode values
    localparam logic [6:0] TR1_80 = 7'h50;
    localparam logic [6:0] TR1_64 = 7'h40;
    localparam logic [6:0] TR1_32 = 7'h20;
    localparam logic [3:0] EOF_SHORT = 4'hb;
    localparam logic [3:0] EOF_LONG = 4'hc;
    localparam logic [6:0] PRE_BASE = 7'h30;
    localparam logic [2:0] SC_LOG2_SUB = 3'h6;
    localparam logic [2:0] SC_LOG2_BPSK = 3'h4;
    localparam logic [2:0] TX_LOG2_BASE = 3'h7;

    typedef struct packed {
        logic [6:0] tr1_fs_units;
        logic skip_sof;
        logic skip_eof;
        logic [3:0] eof_max_etu;
        logic eof_wide_tol;
        logic phase_tol;
        logic [6:0] preamble_len;
        logic [2:0] sc_div_log2;
        logic [3:0] pulse_count;
        logic [2:0] tx_div_log2;
        logic stream_cfg_bad;
        logic rx_crc_check;
        logic crc_to_fifo;
        logic mod_am;
        logic field_det_en;
        logic rfo_hiz;
        logic rx_tolerant;
        logic [1:0] field_on_n;
    } rfo_cfg_t;

    typedef struct packed {
        logic [7:0] frame;
        logic [6:0] stream;
        logic [7:0] aux;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        rfo_cfg_t cfg;
    } rfo_state_t;
endpackage : rfo_pkg

//--- verilog/rfo_regs.sv
`timescale 1ns/1ps
module rfo_regs
    import rfo_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // commands and framer context
    input wire logic set_default_cmd,
    input wire logic analog_preset,
    input wire logic analog_preset_am,
    input wire logic p2p_preset,
    input wire logic [1:0] rx_rate_code,
    input wire logic bpsk_mode,
    input wire logic typea_short_frame,
    input wire logic tx_modulating,
    // decoded configuration
    output rfo_cfg_t cfg
);

    rfo_state_t q;
    rfo_state_t d;
    logic wr_en;
    logic hi_rate;

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign cfg = q.cfg;
    assign wr_en = psel && penable && q.pready && pwrite && pstrb[0];
    assign hi_rate = rx_rate_code == RATE_16UP;

    always_comb
    begin
        d = q;
        d.pready = 1'b0;
        d.pslverr = 1'b0;
        // one wait state, then answer
        if (psel && penable && !q.pready)
        begin
            d.pready = 1'b1;
            d.prdata = 32'h0;
            if (paddr == ADDR_FRAME)
            begin
                d.prdata = {24'h0, q.frame};
            end
            else if (paddr == ADDR_STREAM)
            begin
                d.prdata = {25'h0, q.stream};
            end
            else if (paddr == ADDR_AUX)
            begin
                d.prdata = {24'h0, q.aux};
            end
            else
            begin
                d.pslverr = 1'b1;
            end
        end
        if (wr_en)
        begin
            if (paddr == ADDR_FRAME)
            begin
                d.frame = pwdata[7:0];
            end
            else if (paddr == ADDR_STREAM)
            begin
                d.stream = pwdata[6:0];
            end
            else if (paddr == ADDR_AUX)
            begin
                d.aux = pwdata[7:0];
            end
        end
        if (analog_preset)
        begin
            d.aux[B_MOD] = analog_preset_am;
        end
        if (p2p_preset)
        begin
            d.aux[B_FD] = 1'b1;
        end
        // defaults command leaves the stream register alone
        if (set_default_cmd)
        begin
            d.frame = RST_FRAME;
            d.aux = RST_AUX;
        end
        // minimum turnaround
        case (q.frame[B_TR1+:2])
            2'b01: d.cfg.tr1_fs_units = (rx_rate_code == RATE_128) ? TR1_64 : TR1_32;
            default: d.cfg.tr1_fs_units = TR1_80;
        endcase
        d.cfg.skip_sof = q.frame[B_NO_SOF];
        d.cfg.skip_eof = q.frame[B_NO_EOF];
        d.cfg.eof_wide_tol = hi_rate;
        if (hi_rate || q.frame[B_LONG_EOF])
        begin
            d.cfg.eof_max_etu = EOF_LONG;
        end
        else
        begin
            d.cfg.eof_max_etu = EOF_SHORT;
        end
        d.cfg.phase_tol = q.frame[B_PHASE];
        d.cfg.preamble_len = PRE_BASE + {1'b0, q.frame[B_PREAMBLE+:2], 4'h0};
        // stream mode timing
        if (bpsk_mode)
        begin
            d.cfg.sc_div_log2 = SC_LOG2_BPSK - {1'b0, q.stream[B_SCF+:2]};
        end
        else
        begin
            d.cfg.sc_div_log2 = SC_LOG2_SUB - {1'b0, q.stream[B_SCF+:2]};
        end
        d.cfg.pulse_count = 4'h1 << q.stream[B_SCP+:2];
        d.cfg.tx_div_log2 = TX_LOG2_BASE - q.stream[B_STX+:3];
        d.cfg.stream_cfg_bad = (bpsk_mode && q.stream[B_SCF+:2] == 2'h3)
            || (!bpsk_mode && q.stream[B_SCP+:2] == 2'h0)
            || (q.stream[B_STX+:3] == 3'h7);
        // receive checks and driver control
        d.cfg.rx_crc_check = !(q.aux[B_NO_CRC] || typea_short_frame);
        d.cfg.crc_to_fifo = q.aux[B_CRC_FIFO];
        d.cfg.mod_am = q.aux[B_MOD];
        d.cfg.field_det_en = q.aux[B_FD];
        d.cfg.rfo_hiz = q.aux[B_OOK_HIZ] && !q.aux[B_MOD] && tx_modulating;
        d.cfg.rx_tolerant = q.aux[B_RX_TOL];
        d.cfg.field_on_n = q.aux[B_FIELD_N+:2];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.aux <= RST_AUX;
            q.cfg.tr1_fs_units <= TR1_80;
            q.cfg.eof_max_etu <= EOF_SHORT;
            q.cfg.preamble_len <= PRE_BASE;
            q.cfg.sc_div_log2 <= SC_LOG2_SUB;
            q.cfg.pulse_count <= 4'h1;
            q.cfg.tx_div_log2 <= TX_LOG2_BASE;
            q.cfg.stream_cfg_bad <= 1'b1;
            q.cfg.rx_crc_check <= 1'b1;
            q.cfg.rx_tolerant <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_tr1_short: assert property ((q.frame[7:6] == 2'b01 && rx_rate_code != RATE_128)
        |=> cfg.tr1_fs_units == 7'h20) else $error("tr1 not 32 at high rate");
    a_tr1_unused: assert property (q.frame[7] |=> cfg.tr1_fs_units == 7'h50)
        else $error("unused tr1 code not 80");
    a_eof_long: assert property ((q.frame[3] && !hi_rate) |=> cfg.eof_max_etu == 4'hc)
        else $error("long end delimiter not applied");
    a_eof_wide: assert property (hi_rate |=> cfg.eof_wide_tol && cfg.eof_max_etu == 4'hc)
        else $error("high rate end tolerance wrong");
    a_preamble_len: assert property (##1 cfg.preamble_len == 7'h30 + {1'b0, $past(q.frame[1:0]), 4'h0})
        else $error("preamble length wrong");
    a_stream_keep: assert property ((set_default_cmd && !wr_en) |=> q.stream == $past(q.stream))
        else $error("stream register changed by defaults");
    a_aux_default: assert property (set_default_cmd |=> q.aux == 8'h04 ##1 cfg.rx_tolerant)
        else $error("aux defaults not restored");
    a_crc_skip: assert property ((q.aux[7] || typea_short_frame) |=> !cfg.rx_crc_check)
        else $error("crc check not skipped");
    a_hiz_am: assert property (q.aux[5] |=> !cfg.rfo_hiz)
        else $error("tristate during am");
    a_mod_preset: assert property (analog_preset && !set_default_cmd
        |=> q.aux[5] == $past(analog_preset_am) ##1 cfg.mod_am == $past(analog_preset_am, 2))
        else $error("analog preset not applied");
    a_bit7_zero: assert property ((pready && paddr == ADDR_STREAM && !pslverr) |-> prdata[31:7] == 25'h0)
        else $error("stream bit 7 not zero");
    a_apb_wait: assert property ((psel && penable && !pready) |=> pready)
        else $error("apb answer late");

    // turnaround, delimiters and preamble
    a_tr1_long: assert property ((q.frame[B_TR1+:2] == 2'b01 && rx_rate_code == RATE_128)
        |=> cfg.tr1_fs_units == TR1_64)
        else $error("tr1 not 64 at base rate");
    a_tr1_plain: assert property ((q.frame[B_TR1+:2] == 2'b00)
        |=> cfg.tr1_fs_units == TR1_80)
        else $error("tr1 code 00 not 80");
    a_sof_skip: assert property (
        ##1 cfg.skip_sof == $past(q.frame[B_NO_SOF]))
        else $error("skip start delimiter not applied");
    a_eof_skip: assert property (
        ##1 cfg.skip_eof == $past(q.frame[B_NO_EOF]))
        else $error("skip end delimiter not applied");
    a_eof_short: assert property ((!q.frame[B_LONG_EOF] && !hi_rate)
        |=> cfg.eof_max_etu == EOF_SHORT && !cfg.eof_wide_tol)
        else $error("short end delimiter not applied");
    a_eof_hi_rate: assert property ((hi_rate && !q.frame[B_LONG_EOF])
        |=> cfg.eof_max_etu == EOF_LONG)
        else $error("long end bit changes high rate detection");
    a_phase_tol: assert property (
        ##1 cfg.phase_tol == $past(q.frame[B_PHASE]))
        else $error("phase tolerance not applied");
    a_pre_min: assert property ((q.frame[B_PREAMBLE+:2] == 2'h0)
        |=> cfg.preamble_len == PRE_BASE)
        else $error("shortest preamble wrong");
    a_pre_max: assert property ((q.frame[B_PREAMBLE+:2] == 2'h3)
        |=> cfg.preamble_len == 7'h60)
        else $error("longest preamble wrong");

    // stream mode decode
    a_sc_sub_slow: assert property ((!bpsk_mode && q.stream[B_SCF+:2] == 2'h0)
        |=> cfg.sc_div_log2 == SC_LOG2_SUB)
        else $error("slowest sub-carrier wrong");
    a_sc_sub_fast: assert property ((!bpsk_mode && q.stream[B_SCF+:2] == 2'h3)
        |=> cfg.sc_div_log2 == 3'h3)
        else $error("fastest sub-carrier wrong");
    a_sc_bpsk_slow: assert property ((bpsk_mode && q.stream[B_SCF+:2] == 2'h0)
        |=> cfg.sc_div_log2 == SC_LOG2_BPSK)
        else $error("slowest bpsk rate wrong");
    a_sc_bpsk_fast: assert property ((bpsk_mode && q.stream[B_SCF+:2] == 2'h2)
        |=> cfg.sc_div_log2 == 3'h2)
        else $error("fastest bpsk rate wrong");
    a_bpsk_unused: assert property ((bpsk_mode && q.stream[B_SCF+:2] == 2'h3)
        |=> cfg.stream_cfg_bad)
        else $error("unused bpsk code not flagged");
    a_pulse_one: assert property ((q.stream[B_SCP+:2] == 2'h0)
        |=> cfg.pulse_count == 4'h1)
        else $error("single pulse count wrong");
    a_pulse_eight: assert property ((q.stream[B_SCP+:2] == 2'h3)
        |=> cfg.pulse_count == 4'h8)
        else $error("eight pulse count wrong");
    a_single_sub: assert property ((!bpsk_mode && q.stream[B_SCP+:2] == 2'h0)
        |=> cfg.stream_cfg_bad)
        else $error("single pulse outside bpsk not flagged");
    a_single_bpsk: assert property ((bpsk_mode && q.stream[B_SCF+:2] != 2'h3 && q.stream[B_SCP+:2] == 2'h0
        && q.stream[B_STX+:3] != 3'h7) |=> !cfg.stream_cfg_bad)
        else $error("single pulse in bpsk flagged");
    a_tx_slow: assert property ((q.stream[B_STX+:3] == 3'h0)
        |=> cfg.tx_div_log2 == TX_LOG2_BASE)
        else $error("slowest tx period wrong");
    a_tx_fast: assert property ((q.stream[B_STX+:3] == 3'h6)
        |=> cfg.tx_div_log2 == 3'h1)
        else $error("fastest tx period wrong");
    a_tx_unused: assert property ((q.stream[B_STX+:3] == 3'h7)
        |=> cfg.stream_cfg_bad)
        else $error("unused tx period not flagged");
    a_stream_presets: assert property (((analog_preset || p2p_preset) && !wr_en)
        |=> q.stream == $past(q.stream))
        else $error("stream register changed by preset");
    a_stream_write: assert property ((wr_en && paddr == ADDR_STREAM)
        |=> q.stream == $past(pwdata[6:0]))
        else $error("stream write not stored");

    // receive checks
    a_crc_normal: assert property ((!q.aux[B_NO_CRC] && !typea_short_frame)
        |=> cfg.rx_crc_check)
        else $error("crc check dropped");
    a_crc_auto: assert property (typea_short_frame
        |=> !cfg.rx_crc_check)
        else $error("short frame checked for crc");
    a_crc_fifo: assert property (
        ##1 cfg.crc_to_fifo == $past(q.aux[B_CRC_FIFO]))
        else $error("crc to fifo not applied");
    a_fifo_checks: assert property ((q.aux[B_CRC_FIFO] && !q.aux[B_NO_CRC] && !typea_short_frame)
        |=> cfg.rx_crc_check)
        else $error("crc to fifo drops check");
    a_rx_tol: assert property (
        ##1 cfg.rx_tolerant == $past(q.aux[B_RX_TOL]))
        else $error("receive tolerance not applied");

    // modulation, detector and drivers
    a_mod_type: assert property (
        ##1 cfg.mod_am == $past(q.aux[B_MOD]))
        else $error("modulation type not applied");
    a_mod_write: assert property ((wr_en && paddr == ADDR_AUX && !analog_preset && !set_default_cmd)
        |=> q.aux[B_MOD] == $past(pwdata[B_MOD]))
        else $error("modulation write not stored");
    a_mod_hold: assert property ((!analog_preset && !set_default_cmd && !wr_en)
        |=> q.aux[B_MOD] == $past(q.aux[B_MOD]))
        else $error("modulation changed without cause");
    a_fd_enable: assert property (
        ##1 cfg.field_det_en == $past(q.aux[B_FD]))
        else $error("field detector enable not applied");
    a_p2p_preset: assert property ((p2p_preset && !set_default_cmd)
        |=> q.aux[B_FD])
        else $error("peer preset not applied");
    a_hiz_ook: assert property ((q.aux[B_OOK_HIZ] && !q.aux[B_MOD] && tx_modulating)
        |=> cfg.rfo_hiz)
        else $error("drivers not tristated in ook");
    a_hiz_off: assert property (!q.aux[B_OOK_HIZ]
        |=> !cfg.rfo_hiz)
        else $error("drivers tristated while disabled");

    // field-on value
    a_field_n: assert property (
        ##1 cfg.field_on_n == $past(q.aux[B_FIELD_N+:2]))
        else $error("field-on value wrong");

    // bus answer and write masking
    a_ready_pulse: assert property (pready
        |=> !pready)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (pslverr
        |-> pready)
        else $error("error without ready");
    a_err_data: assert property ((pready && pslverr)
        |-> prdata == 32'h0)
        else $error("unmapped read data not zero");
    a_write_masked: assert property ((psel && penable && pready && pwrite && !set_default_cmd
        && (!pstrb[0] || pslverr)) |=> q.frame == $past(q.frame) && q.stream == $past(q.stream))
        else $error("refused write changed a register");

endmodule : rfo_regs

//--- bench/rfo_rf_peer.sv
`timescale 1ns/1ps
module rfo_rf_peer
(
    // framer context seen by the register block
    output logic [1:0] rx_rate_code,
    output logic bpsk_mode,
    output logic typea_short_frame,
    output logic tx_modulating
);
    initial {rx_rate_code, bpsk_mode, typea_short_frame, tx_modulating} = 5'h00;
    // context changes only between frames, after the host has chosen the modulation
    task set_ctx(input logic [1:0] r, input logic b, input logic s, input logic m);
    begin
        rx_rate_code <= r;
        bpsk_mode <= b;
        typea_short_frame <= s;
        tx_modulating <= m;
    end
    endtask : set_ctx
endmodule : rfo_rf_peer

//--- bench/rfo_regs_tb.sv
`timescale 1ns/1ps
module rfo_regs_tb;
    import rfo_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr;
    logic dflt = 1'b0, apre = 1'b0, apre_am = 1'b0, ppre = 1'b0;
    logic [1:0] rate;
    logic bpsk, short_fr, txmod;
    rfo_cfg_t cfg;
    int failures = 0, total_checks = 0, cycles = 0;
    logic [31:0] rdv;
    logic err;

    initial forever #2 pclk = ~pclk;

    rfo_rf_peer u_rfo_rf_peer (.rx_rate_code(rate), .bpsk_mode(bpsk), .typea_short_frame(short_fr),
        .tx_modulating(txmod));
    rfo_regs u_rfo_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .set_default_cmd(dflt), .analog_preset(apre), .analog_preset_am(apre_am), .p2p_preset(ppre),
        .rx_rate_code(rate), .bpsk_mode(bpsk), .typea_short_frame(short_fr), .tx_modulating(txmod), .cfg(cfg));

    task close_out;
    begin
        if (failures == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask : close_out

    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures = failures + 1;
            close_out();
        end
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask : chk

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask : apb

    task rdchk(input logic [11:0] a, input logic [31:0] exp);
    begin
        apb(1'b0, a, 32'h0);
        chk("prdata", rdv, exp);
    end
    endtask : rdchk

    task ctx(input logic [1:0] r, input logic b, input logic s, input logic m);
    begin
        @(posedge pclk);
        u_rfo_rf_peer.set_ctx(r, b, s, m);
        repeat (3) @(posedge pclk);
    end
    endtask : ctx

    task pulse(input int k);
    begin
        @(posedge pclk);
        if (k == 0) dflt <= 1'b1;
        if (k == 1) apre <= 1'b1;
        if (k == 2) ppre <= 1'b1;
        @(posedge pclk);
        {dflt, apre, ppre} <= 3'h0;
    end
    endtask : pulse

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(ADDR_FRAME, 32'h00);
        rdchk(ADDR_STREAM, 32'h00);
        rdchk(ADDR_AUX, 32'h04);
        apb(1'b0, 12'h028, 32'h0);
        chk("pslverr", {31'h0, err}, 32'h1);
        apb(1'b1, ADDR_FRAME, 32'h7c);
        ctx(2'h0, 1'b0, 1'b0, 1'b0);
        chk("tr1", cfg.tr1_fs_units, 32'h40);
        chk("sof", {cfg.skip_sof, cfg.skip_eof, cfg.phase_tol}, 32'h7);
        chk("eof", cfg.eof_max_etu, 32'hc);
        ctx(2'h3, 1'b0, 1'b0, 1'b0);
        chk("tr1", cfg.tr1_fs_units, 32'h20);
        chk("wide", cfg.eof_wide_tol, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, ADDR_FRAME, i);
            ctx(2'h0, 1'b0, 1'b0, 1'b0);
            chk("tr1", cfg.tr1_fs_units, 32'h50);
            chk("eof", {cfg.eof_wide_tol, cfg.eof_max_etu}, 32'hb);
            chk("pre", cfg.preamble_len, 48 + 16 * i);
            apb(1'b1, ADDR_STREAM, {25'h0, i[1:0], i[1:0], i[2:0]});
            ctx(2'h0, 1'b0, 1'b0, 1'b0);
            chk("scf", cfg.sc_div_log2, 6 - i);
            chk("scp", cfg.pulse_count, 1 << i);
            chk("stx", cfg.tx_div_log2, 7 - i);
            chk("bad", cfg.stream_cfg_bad, i == 0);
        end
        for (int k = 2; k < 4; k++)
        begin
            apb(1'b1, ADDR_FRAME, k << 6);
            ctx(2'h3, 1'b0, 1'b0, 1'b0);
            chk("tr1", cfg.tr1_fs_units, 32'h50);
        end
        apb(1'b1, ADDR_FRAME, 32'h48);
        ctx(2'h2, 1'b0, 1'b0, 1'b0);
        chk("tr1", cfg.tr1_fs_units, 32'h20);
        chk("eof", {cfg.eof_wide_tol, cfg.eof_max_etu}, 32'hc);
        apb(1'b1, ADDR_STREAM, 32'h48);
        ctx(2'h0, 1'b1, 1'b0, 1'b0);
        chk("bpsk", {cfg.stream_cfg_bad, cfg.sc_div_log2}, 32'h2);
        apb(1'b1, ADDR_STREAM, 32'h40);
        ctx(2'h0, 1'b1, 1'b0, 1'b0);
        chk("bpsk1", {cfg.stream_cfg_bad, cfg.pulse_count}, 32'h1);
        apb(1'b1, ADDR_STREAM, 32'hff);
        ctx(2'h0, 1'b1, 1'b0, 1'b0);
        chk("bad", cfg.stream_cfg_bad, 32'h1);
        rdchk(ADDR_STREAM, 32'h7f);
        apb(1'b1, ADDR_AUX, 32'h80);
        ctx(2'h0, 1'b0, 1'b0, 1'b0);
        chk("crc", cfg.rx_crc_check, 32'h0);
        apb(1'b1, ADDR_AUX, 32'h00);
        ctx(2'h0, 1'b0, 1'b1, 1'b0);
        chk("crc", cfg.rx_crc_check, 32'h0);
        apb(1'b1, ADDR_AUX, 32'h78);
        ctx(2'h0, 1'b0, 1'b0, 1'b1);
        chk("aux", {cfg.rx_crc_check, cfg.crc_to_fifo, cfg.mod_am, cfg.field_det_en, cfg.rfo_hiz}, 32'h1e);
        apb(1'b1, ADDR_AUX, 32'h4b);
        ctx(2'h0, 1'b0, 1'b0, 1'b1);
        chk("aux", {cfg.rfo_hiz, cfg.rx_tolerant, cfg.field_on_n}, 32'hb);
        apb(1'b1, ADDR_FRAME, 32'h55);
        apb(1'b1, ADDR_STREAM, 32'h15);
        pstrb <= 4'he;
        apb(1'b1, ADDR_STREAM, 32'h2a);
        pstrb <= 4'hf;
        apb(1'b1, 12'h028, 32'h2a);
        pulse(0);
        rdchk(ADDR_FRAME, 32'h00);
        rdchk(ADDR_AUX, 32'h04);
        rdchk(ADDR_STREAM, 32'h15);
        apre_am <= 1'b1;
        pulse(1);
        rdchk(ADDR_AUX, 32'h24);
        pulse(2);
        rdchk(ADDR_AUX, 32'h34);
        ctx(2'h0, 1'b0, 1'b0, 1'b0);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(ADDR_STREAM, 32'h00);
        rdchk(ADDR_AUX, 32'h04);
        chk("rst", {cfg.rx_tolerant, cfg.tr1_fs_units}, 32'hd0);
        close_out();
    end
endmodule : rfo_regs_tb
